// file: design/mudpc_pkg.sv
// Package: register map, field layouts and constants of the delay phase controller
package mudpc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] ADDR_IRQ_EN = 8'h03;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
   localparam logic [7:0] ADDR_PARM = 8'h24;
   localparam logic [7:0] ADDR_SRCH = 8'h2F;
   localparam logic [7:0] ADDR_DCC = 8'h30;
   localparam logic [7:0] ADDR_CLKN = 8'h31;
   localparam logic [7:0] ADDR_CLKP = 8'h32;
   localparam logic [7:0] ADDR_CTRL = 8'h33;
   localparam logic [7:0] ADDR_DLY_LO = 8'h39;
   localparam logic [7:0] ADDR_DLY_HI = 8'h3A;
   localparam logic [7:0] ADDR_BOOST = 8'h3E;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt bit positions and the parameter update bit
   localparam int IRQ_PARITY = 7;
   localparam int IRQ_UPD_SET = 6;
   localparam int IRQ_UPD_CLR = 5;
   localparam int IRQ_LOCK_ACQ = 3;
   localparam int IRQ_LOCK_LOST = 2;
   localparam int IRQ_SAT = 1;
   localparam int PARM_BIT = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_BOOST = 8'h08;

   ////////////////////////////////////////////////////////////////////////////
   // Limits and encodings
   localparam logic [8:0] DELAY_MAX = 9'h1AF;
   localparam logic [8:0] DELAY_MIN = 9'h000;
   localparam logic [4:0] PHASE_MAX = 5'h10;
   localparam logic [4:0] PHASE_MIN = 5'h00;
   localparam logic [4:0] SLOPE_STEP = 5'h02;
   localparam logic [4:0] COARSE_TOL = 5'h02;
   localparam logic [4:0] EXACT_TOL = 5'h00;
   localparam int LOSS_LIMIT_DEF = 5;
   localparam int GUARD_SCALE = 7;
   localparam int TYPICAL_LOCK_CYCLES = 180000;
   localparam logic [1:0] DIR_DOWN = 2'h0;
   localparam logic [1:0] DIR_UP = 2'h1;
   localparam logic [1:0] DIR_ALT = 2'h2;
   localparam logic [1:0] MODE_SEARCH_TRACK = 2'h0;
   localparam logic [1:0] MODE_TRACK_ONLY = 2'h1;
   localparam logic [1:0] MODE_SEARCH_ONLY = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Field layouts
   typedef struct packed {
      logic restart_on_loss;
      logic slope_pos;
      logic [1:0] mode;
      logic sample_readback;
      logic [1:0] aux;
      logic enable;
   } mudpc_ctrl_t;

   typedef struct packed {
      logic search_exactness;
      logic spare;
      logic track_err;
      logic [4:0] endpoint_margin;
   } mudpc_srch_t;

   typedef struct packed {
      logic delay_lsb;
      logic [1:0] search_dir;
      logic [4:0] target_phase;
   } mudpc_dlylo_t;

   typedef struct packed {
      logic [7:0] duty_cycle;
      logic [7:0] neg_clock_cm_level;
      logic [7:0] pos_clock_cm_level;
      logic [7:0] boost;
   } mudpc_analog_t;

endpackage

// file: design/mudpc_irq_bank.sv
// Interrupt enable, sticky status with write-one-to-clear, and pin output
`timescale 1ns/1ps
`default_nettype none
module mudpc_irq_bank #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Register writes
   input wire logic i_en_we,
   input wire logic i_stat_we,
   input wire logic [W-1:0] i_wdata,
   // Events
   input wire logic [W-1:0] i_set,
   input wire logic [W-1:0] i_hw_clr,
   // Outputs
   output logic [W-1:0] o_enable,
   output logic [W-1:0] o_status,
   output logic o_irq
);

   generate
      if (W < 1) begin : g_bad_width
         $error("mudpc_irq_bank: width must be positive");
      end
   endgenerate

   logic [W-1:0] enable_reg;
   logic [W-1:0] status_reg;
   logic [W-1:0] status_next;
   logic irq_reg;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         enable_reg <= '0;
      end else if (i_en_we) begin
         enable_reg <= i_wdata;
      end
   end

   // Set beats any clear landing in the same cycle
   always_comb begin
      status_next = status_reg & ~(i_stat_we ? i_wdata : {W{1'b0}});
      status_next = status_next & ~i_hw_clr;
      status_next = status_next | (i_set & enable_reg);
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   // Pin only says something is pending
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_next & enable_reg);
      end
   end

   assign o_enable = enable_reg;
   assign o_status = status_reg;
   assign o_irq = irq_reg;

endmodule
`default_nettype wire

// file: design/mudpc_top.sv
// Delay phase controller: register file, search, slope check, tracking, readback
`timescale 1ns/1ps
`default_nettype none
module mudpc_top #(
   parameter int LOSS_LIMIT = mudpc_pkg::LOSS_LIMIT_DEF
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Register port behind the serial interface
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Phase comparator and delay line
   input wire logic [4:0] i_phase,
   input wire logic i_phase_valid,
   output logic [8:0] o_delay_code,
   output mudpc_pkg::mudpc_analog_t o_analog_cfg,
   // Other interrupt sources
   input wire logic i_parity_err,
   input wire logic i_sat_err,
   // Status
   output logic o_locked,
   output logic o_parameter_update,
   output logic o_irq
);

   generate
      if (LOSS_LIMIT < 1 || LOSS_LIMIT > 16) begin : g_bad_limit
         $error("mudpc_top: LOSS_LIMIT out of range");
      end
   endgenerate

   typedef enum logic [2:0] {S_IDLE, S_SEEK, S_UP, S_DN, S_TRACK, S_HOLD, S_FAIL} mudpc_state_t;

   function automatic logic [4:0] mudpc_pdiff(input logic [4:0] a, input logic [4:0] b);
      mudpc_pdiff = (a > b) ? (a - b) : (b - a);
   endfunction

   function automatic logic mudpc_wr(input logic we, input logic [7:0] a, input logic [7:0] b);
      mudpc_wr = we && (a == b);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   mudpc_pkg::mudpc_ctrl_t ctrl_reg;
   mudpc_pkg::mudpc_srch_t srch_reg;
   mudpc_pkg::mudpc_dlylo_t dlylo_reg;
   mudpc_pkg::mudpc_analog_t ana_reg;
   logic [7:0] dlyhi_reg;
   logic [7:0] parm_reg;
   logic [7:0] rdata_reg;
   logic [7:0] irq_enable;
   logic [7:0] irq_status;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_reg <= mudpc_pkg::RST_ZERO;
         srch_reg <= mudpc_pkg::RST_ZERO;
         dlylo_reg <= mudpc_pkg::RST_ZERO;
         dlyhi_reg <= mudpc_pkg::RST_ZERO;
         parm_reg <= mudpc_pkg::RST_ZERO;
         ana_reg <= {mudpc_pkg::RST_ZERO, mudpc_pkg::RST_ZERO, mudpc_pkg::RST_ZERO,
                     mudpc_pkg::RST_BOOST};
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            mudpc_pkg::ADDR_CTRL: ctrl_reg <= i_reg_wdata;
            mudpc_pkg::ADDR_SRCH: srch_reg <= i_reg_wdata;
            mudpc_pkg::ADDR_DLY_LO: dlylo_reg <= i_reg_wdata;
            mudpc_pkg::ADDR_DLY_HI: dlyhi_reg <= i_reg_wdata;
            mudpc_pkg::ADDR_PARM: parm_reg <= i_reg_wdata;
            mudpc_pkg::ADDR_DCC: ana_reg.duty_cycle <= i_reg_wdata;
            mudpc_pkg::ADDR_CLKN: ana_reg.neg_clock_cm_level <= i_reg_wdata;
            mudpc_pkg::ADDR_CLKP: ana_reg.pos_clock_cm_level <= i_reg_wdata;
            mudpc_pkg::ADDR_BOOST: ana_reg.boost <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Derived configuration

   logic [8:0] start_code;
   logic [4:0] tgt;
   logic tgt_ok;
   logic [8:0] margin;
   logic [4:0] tol;
   logic [4:0] ph;
   logic phv;

   assign start_code = {dlyhi_reg, dlylo_reg.delay_lsb};
   assign tgt = dlylo_reg.target_phase;
   assign tgt_ok = (tgt <= mudpc_pkg::PHASE_MAX);
   assign margin = 9'(32'(srch_reg.endpoint_margin) * mudpc_pkg::GUARD_SCALE);
   assign tol = srch_reg.search_exactness ? mudpc_pkg::EXACT_TOL : mudpc_pkg::COARSE_TOL;
   assign ph = i_phase;
   assign phv = i_phase_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Engine state

   mudpc_state_t st_reg;
   logic [8:0] dly_reg;
   logic [8:0] up_ptr_reg;
   logic [8:0] dn_ptr_reg;
   logic turn_reg;
   logic band_reg;
   logic [8:0] base_reg;
   logic [4:0] p0_reg;
   logic [4:0] pup_reg;
   logic locked_reg;

   // Seek step selection
   logic band_any;
   logic [8:0] lo_lim;
   logic [8:0] hi_lim;
   logic can_up;
   logic can_dn;
   logic go_up;
   logic go_dn;
   logic seek_wrap;

   always_comb begin
      band_any = band_reg || (dlylo_reg.search_dir != mudpc_pkg::DIR_ALT);
      lo_lim = band_any ? mudpc_pkg::DELAY_MIN : margin;
      hi_lim = band_any ? mudpc_pkg::DELAY_MAX : (mudpc_pkg::DELAY_MAX - margin);
      can_up = (up_ptr_reg < hi_lim) && (dlylo_reg.search_dir != mudpc_pkg::DIR_DOWN);
      can_dn = (dn_ptr_reg > lo_lim) && (dlylo_reg.search_dir != mudpc_pkg::DIR_UP);
      go_up = can_up && (turn_reg || !can_dn);
      go_dn = can_dn && !go_up;
      seek_wrap = !can_up && !can_dn && !band_any;
   end

   // Measurement checks
   logic ph_match;
   logic up_stop;
   logic dn_stop;
   logic slope_ok;
   logic found;
   logic do_seek;
   logic trk_match;
   logic lock_ev;
   logic lost_ev;

   always_comb begin
      ph_match = tgt_ok && (mudpc_pdiff(ph, tgt) <= tol);
      up_stop = (mudpc_pdiff(ph, p0_reg) >= mudpc_pkg::SLOPE_STEP) ||
                (ph == mudpc_pkg::PHASE_MAX) || (ph == mudpc_pkg::PHASE_MIN) ||
                (dly_reg == mudpc_pkg::DELAY_MAX);
      dn_stop = (mudpc_pdiff(ph, p0_reg) >= mudpc_pkg::SLOPE_STEP) ||
                (ph == mudpc_pkg::PHASE_MAX) || (ph == mudpc_pkg::PHASE_MIN) ||
                (dly_reg == mudpc_pkg::DELAY_MIN);
      if (ctrl_reg.slope_pos) begin
         slope_ok = (pup_reg >= tgt) && (ph <= tgt) && (pup_reg != ph);
      end else begin
         slope_ok = (pup_reg <= tgt) && (ph >= tgt) && (pup_reg != ph);
      end
      found = phv && (st_reg == S_DN) && dn_stop && slope_ok;
      do_seek = phv && (((st_reg == S_SEEK) && !ph_match) ||
                        ((st_reg == S_DN) && dn_stop && !slope_ok));
      trk_match = phv && (st_reg == S_TRACK) && !locked_reg && tgt_ok && (ph == tgt);
      lock_ev = found || trk_match;
      lost_ev = phv && locked_reg && ((st_reg == S_TRACK) || (st_reg == S_HOLD)) &&
                (32'(mudpc_pdiff(ph, tgt)) > LOSS_LIMIT);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Search and track engine

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= S_IDLE;
         dly_reg <= mudpc_pkg::DELAY_MIN;
         up_ptr_reg <= mudpc_pkg::DELAY_MIN;
         dn_ptr_reg <= mudpc_pkg::DELAY_MIN;
         turn_reg <= 1'b1;
         band_reg <= 1'b0;
         base_reg <= mudpc_pkg::DELAY_MIN;
         p0_reg <= mudpc_pkg::PHASE_MIN;
         pup_reg <= mudpc_pkg::PHASE_MIN;
      end else if (!ctrl_reg.enable) begin
         // Manual mode: delay line follows the written code
         st_reg <= S_IDLE;
         dly_reg <= start_code;
      end else if ((st_reg == S_IDLE) || (lost_ev && ctrl_reg.restart_on_loss)) begin
         dly_reg <= start_code;
         up_ptr_reg <= start_code;
         dn_ptr_reg <= start_code;
         turn_reg <= 1'b1;
         band_reg <= 1'b0;
         if (ctrl_reg.mode == mudpc_pkg::MODE_TRACK_ONLY) begin
            st_reg <= S_TRACK;
         end else begin
            st_reg <= S_SEEK;
         end
      end else if (do_seek) begin
         st_reg <= S_SEEK;
         if (go_up) begin
            up_ptr_reg <= up_ptr_reg + 9'h001;
            dly_reg <= up_ptr_reg + 9'h001;
            turn_reg <= 1'b0;
         end else if (go_dn) begin
            dn_ptr_reg <= dn_ptr_reg - 9'h001;
            dly_reg <= dn_ptr_reg - 9'h001;
            turn_reg <= 1'b1;
         end else if (seek_wrap) begin
            band_reg <= 1'b1;
         end else if (srch_reg.track_err) begin
            st_reg <= S_FAIL;
         end else begin
            dly_reg <= start_code;
            up_ptr_reg <= start_code;
            dn_ptr_reg <= start_code;
            turn_reg <= 1'b1;
            band_reg <= 1'b0;
         end
      end else if (phv) begin
         case (st_reg)
            S_SEEK: begin
               base_reg <= dly_reg;
               p0_reg <= ph;
               st_reg <= S_UP;
               if (dly_reg != mudpc_pkg::DELAY_MAX) begin
                  dly_reg <= dly_reg + 9'h001;
               end
            end
            S_UP: begin
               if (up_stop) begin
                  pup_reg <= ph;
                  st_reg <= S_DN;
                  dly_reg <= (base_reg == mudpc_pkg::DELAY_MIN) ? base_reg :
                             (base_reg - 9'h001);
               end else begin
                  dly_reg <= dly_reg + 9'h001;
               end
            end
            S_DN: begin
               if (found) begin
                  dly_reg <= base_reg;
                  // Search-only parks on the found code without tracking
                  st_reg <= (ctrl_reg.mode == mudpc_pkg::MODE_SEARCH_ONLY) ? S_HOLD :
                            S_TRACK;
               end else begin
                  dly_reg <= dly_reg - 9'h001;
               end
            end
            S_TRACK: begin
               // Direction comes from the configured slope, never re-measured
               if ((ph < tgt) == ctrl_reg.slope_pos) begin
                  if ((ph != tgt) && (dly_reg != mudpc_pkg::DELAY_MAX)) begin
                     dly_reg <= dly_reg + 9'h001;
                  end
               end else if ((ph != tgt) && (dly_reg != mudpc_pkg::DELAY_MIN)) begin
                  dly_reg <= dly_reg - 9'h001;
               end
            end
            S_HOLD: ;
            S_FAIL: ;
            default: st_reg <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lock state

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         locked_reg <= 1'b0;
      end else if (!ctrl_reg.enable || (st_reg == S_IDLE)) begin
         locked_reg <= 1'b0;
      end else if (lost_ev) begin
         locked_reg <= 1'b0;
      end else if (lock_ev) begin
         locked_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Readback sampling

   logic sample_d_reg;
   logic rb_valid_reg;
   logic [8:0] rb_dly_reg;
   logic [4:0] rb_ph_reg;
   logic [4:0] last_ph_reg;
   logic sample_edge;

   assign sample_edge = ctrl_reg.sample_readback && !sample_d_reg;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sample_d_reg <= 1'b0;
         last_ph_reg <= mudpc_pkg::PHASE_MIN;
      end else begin
         sample_d_reg <= ctrl_reg.sample_readback;
         if (phv) begin
            last_ph_reg <= ph;
         end
      end
   end

   // Holding the bit high does not refresh the captured values
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rb_valid_reg <= 1'b0;
         rb_dly_reg <= mudpc_pkg::DELAY_MIN;
         rb_ph_reg <= mudpc_pkg::PHASE_MIN;
      end else if (sample_edge) begin
         rb_valid_reg <= 1'b1;
         rb_dly_reg <= dly_reg;
         rb_ph_reg <= last_ph_reg;
      end else if (mudpc_wr(i_reg_wr, i_reg_addr, mudpc_pkg::ADDR_DLY_LO) ||
                   mudpc_wr(i_reg_wr, i_reg_addr, mudpc_pkg::ADDR_DLY_HI)) begin
         rb_valid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parameter update bit registering

   logic parm_q1_reg;
   logic parm_q2_reg;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         parm_q1_reg <= 1'b0;
         parm_q2_reg <= 1'b0;
      end else begin
         parm_q1_reg <= parm_reg[mudpc_pkg::PARM_BIT];
         parm_q2_reg <= parm_q1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts

   logic [7:0] irq_set;
   logic [7:0] irq_hw_clr;

   always_comb begin
      irq_set = '0;
      irq_set[mudpc_pkg::IRQ_PARITY] = i_parity_err;
      irq_set[mudpc_pkg::IRQ_UPD_SET] = parm_q1_reg && !parm_q2_reg;
      irq_set[mudpc_pkg::IRQ_UPD_CLR] = !parm_q1_reg && parm_q2_reg;
      irq_set[mudpc_pkg::IRQ_LOCK_ACQ] = lock_ev;
      irq_set[mudpc_pkg::IRQ_LOCK_LOST] = lost_ev;
      irq_set[mudpc_pkg::IRQ_SAT] = i_sat_err;
      irq_hw_clr = '0;
      irq_hw_clr[mudpc_pkg::IRQ_LOCK_ACQ] = lost_ev;
   end

   mudpc_irq_bank #(
      .W(8)
   ) u_irq (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_en_we(mudpc_wr(i_reg_wr, i_reg_addr, mudpc_pkg::ADDR_IRQ_EN)),
      .i_stat_we(mudpc_wr(i_reg_wr, i_reg_addr, mudpc_pkg::ADDR_IRQ_STAT)),
      .i_wdata(i_reg_wdata),
      .i_set(irq_set),
      .i_hw_clr(irq_hw_clr),
      .o_enable(irq_enable),
      .o_status(irq_status),
      .o_irq(o_irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register read

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_reg <= mudpc_pkg::RST_ZERO;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            mudpc_pkg::ADDR_IRQ_EN: rdata_reg <= irq_enable;
            mudpc_pkg::ADDR_IRQ_STAT: rdata_reg <= irq_status;
            mudpc_pkg::ADDR_PARM: rdata_reg <= parm_reg;
            mudpc_pkg::ADDR_SRCH: rdata_reg <= srch_reg;
            mudpc_pkg::ADDR_DCC: rdata_reg <= ana_reg.duty_cycle;
            mudpc_pkg::ADDR_CLKN: rdata_reg <= ana_reg.neg_clock_cm_level;
            mudpc_pkg::ADDR_CLKP: rdata_reg <= ana_reg.pos_clock_cm_level;
            mudpc_pkg::ADDR_CTRL: rdata_reg <= ctrl_reg;
            mudpc_pkg::ADDR_DLY_LO: begin
               rdata_reg <= rb_valid_reg ?
                            {rb_dly_reg[0], dlylo_reg.search_dir, rb_ph_reg} : dlylo_reg;
            end
            mudpc_pkg::ADDR_DLY_HI: rdata_reg <= rb_valid_reg ? rb_dly_reg[8:1] : dlyhi_reg;
            mudpc_pkg::ADDR_BOOST: rdata_reg <= ana_reg.boost;
            default: rdata_reg <= mudpc_pkg::RST_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_reg_rdata = rdata_reg;
   assign o_delay_code = dly_reg;
   assign o_analog_cfg = ana_reg;
   assign o_locked = locked_reg;
   assign o_parameter_update = parm_q1_reg;

endmodule
`default_nettype wire

// file: verification/mudpc_chk.sv
// Checker: port-level properties of the delay phase controller
`timescale 1ns/1ps
`default_nettype none
module mudpc_chk (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Ports watched
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [8:0] o_delay_code,
   input wire logic o_locked,
   input wire logic o_parameter_update,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////////
   delay_max_a: assert property (o_delay_code <= 9'h1AF) else $error("delay above 431");
   track_step_a:
      assert property (o_locked |=> !o_locked || (o_delay_code == $past(o_delay_code))
         || (o_delay_code == $past(o_delay_code) + 9'h001)
         || (o_delay_code + 9'h001 == $past(o_delay_code))) else $error("track step too big");
   unmapped_rd_a:
      assert property (i_reg_rd && !(i_reg_addr inside {8'h03, 8'h04, 8'h24, 8'h2F, 8'h30,
         8'h31, 8'h32, 8'h33, 8'h39, 8'h3A, 8'h3E}) |=> o_reg_rdata == 8'h00)
         else $error("unmapped read not zero");
   // Read data is registered, so it must not drift between reads
   rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
   irq_en_rb_a:
      assert property (i_reg_wr && i_reg_addr == 8'h03 ##2 i_reg_rd && i_reg_addr == 8'h03
         |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("enable readback wrong");
   param_upd_a:
      assert property (i_reg_wr && i_reg_addr == 8'h24 |-> ##2 o_parameter_update
         == $past(i_reg_wdata[7], 2)) else $error("update bit not registered");
   irq_hold_a:
      assert property ($fell(o_irq) |-> $past(i_reg_wr) || $past(i_reg_wr, 2) || $fell(o_locked))
         else $error("irq dropped without write");
   irq_mask_a:
      assert property (i_reg_wr && i_reg_addr == 8'h03 && i_reg_wdata == 8'h00 ##1 !i_reg_wr
         |=> !o_irq) else $error("irq with all disabled");
endmodule
`default_nettype wire

// file: verification/mudpc_phase_model.sv
// Partner: phase comparator with a rising phase curve over the delay line
`timescale 1ns/1ps
`default_nettype none
module mudpc_phase_model (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Delay line and commanded offset
   input wire logic [8:0] i_delay_code,
   input wire logic [4:0] i_shift,
   // Measurement
   output logic [4:0] o_phase,
   output logic o_phase_valid
);
   logic [1:0] cnt_reg;
   int p;
   always_comb begin
      p = (int'(i_delay_code) < 100) ? 0 : (int'(i_delay_code) - 100) / 8;
      if (p > 16) p = 16;
      p = p - int'(i_shift);
      if (p < 0) p = 0;
   end
   // Phase lines toggle between samples so a stale value is never seen as fresh
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= 2'h0;
         o_phase <= 5'h00;
         o_phase_valid <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         o_phase_valid <= (cnt_reg == 2'h3);
         o_phase <= (cnt_reg == 2'h3) ? p[4:0] : ~o_phase;
      end
   end
endmodule
`default_nettype wire

// file: verification/mu_delay_phase_controller_bench.sv
// Testbench: register-level run of the delay phase controller
`timescale 1ns/1ps
`default_nettype none
module mu_delay_phase_controller_bench;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, perr = 0, serr = 0;
   logic [7:0] addr = 8'h00, wd = 8'h00, rv, rdata;
   logic [4:0] shift = 5'h00, ph;
   logic [8:0] dly;
   logic pv, locked, upd, irq;
   mudpc_pkg::mudpc_analog_t acfg;
   int bad_count = 0, checks_done = 0, cyc = 0, exp_d = 0;
   mudpc_top i_mudpc_top (.i_clock(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_phase(ph),
      .i_phase_valid(pv), .o_delay_code(dly), .o_analog_cfg(acfg), .i_parity_err(perr),
      .i_sat_err(serr), .o_locked(locked), .o_parameter_update(upd), .o_irq(irq));
   mudpc_phase_model i_mudpc_phase_model (.i_clock(clk), .i_rst_n(rst_n), .i_delay_code(dly),
      .i_shift(shift), .o_phase(ph), .o_phase_valid(pv));
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task close_out;
      if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Ceiling well above the short lock the partner curve allows
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         close_out();
      end
   end
   task chk(input logic [8:0] seen, input logic [8:0] exp, input string nm);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wrr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk) {wr, addr, wd} = {1'b1, a, d};
      @(negedge clk) wr = 0;
   endtask
   task rdr(input logic [7:0] a);
      @(negedge clk) {rd, addr} = {1'b1, a};
      @(negedge clk) rd = 0;
      rv = rdata;
   endtask
   task pulse(input int b);
      @(negedge clk) {perr, serr} = {b == 7, b == 1};
      @(negedge clk) {perr, serr} = 2'h0;
   endtask
   function int fph(input int d);
      return (d < 100) ? 0 : ((d - 100) / 8 > 16 ? 16 : (d - 100) / 8);
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int k;
      k = $urandom(32'hdad5);
      repeat (20) @(negedge clk);
      rst_n = 1;
      rdr(8'h3E);
      chk(rv, 8'h08, "boost reset");
      rdr(8'h77);
      chk(rv, 8'h00, "unmapped");
      k = $urandom;
      wrr(8'h03, k[7:0]);
      rdr(8'h03);
      chk(rv, k[7:0], "enable rw");
      wrr(8'h3E, 8'h38);
      chk(acfg.boost, 8'h38, "boost cfg");
      wrr(8'h2F, 8'hCE);
      wrr(8'h33, 8'h42);
      wrr(8'h39, 8'h4E);
      wrr(8'h3A, 8'h6C);
      wrr(8'h03, 8'h00);
      wrr(8'h04, 8'hFE);
      wrr(8'h03, 8'h0C);
      wrr(8'h33, 8'h43);
      // Model search: alternate outwards from code 216 to the first code giving 14
      for (k = 0; k < 200 && exp_d == 0; k++) begin
         if (fph(216 + k) == 14) exp_d = 216 + k;
         else if (fph(216 - k) == 14) exp_d = 216 - k;
      end
      for (k = 0; k < 20000 && locked !== 1'b1; k++) @(negedge clk);
      chk(locked, 1, "locked");
      chk(dly, exp_d, "lock delay");
      rdr(8'h04);
      chk(rv, 8'h08, "lock status");
      chk(irq, 1, "irq lock");
      wrr(8'h33, 8'h4B);
      rdr(8'h39);
      chk(rv, {exp_d[0], 2'h2, 5'h0E}, "rb low");
      rdr(8'h3A);
      chk(rv, exp_d[8:1], "rb high");
      shift = 5'h10 + 5'($urandom % 4);
      repeat (2000) @(negedge clk);
      chk(locked, 0, "lost");
      chk(dly, 9'h1AF, "track clamp");
      rdr(8'h04);
      chk(rv, 8'h04, "lost status");
      rdr(8'h3A);
      chk(rv, exp_d[8:1], "held sample");
      wrr(8'h33, 8'h43);
      wrr(8'h33, 8'h4B);
      rdr(8'h39);
      chk(rv, 8'hC0, "resample low");
      rdr(8'h3A);
      chk(rv, 8'hD7, "resample high");
      wrr(8'h04, 8'h00);
      rdr(8'h04);
      chk(rv, 8'h04, "w0 keeps");
      chk(irq, 1, "irq pending");
      wrr(8'h04, 8'h04);
      rdr(8'h04);
      chk(rv, 8'h00, "w1 clears");
      chk(irq, 0, "irq cleared");
      for (k = 1; k < 8; k += 6) begin
         wrr(8'h03, 8'h00);
         pulse(k);
         rdr(8'h04);
         chk(rv, 8'h00, "gated");
         wrr(8'h03, 8'h01 << k);
         pulse(k);
         rdr(8'h04);
         chk(rv, 8'h01 << k, "source");
         chk(irq, 1, "irq source");
         wrr(8'h04, 8'h01 << k);
      end
      wrr(8'h03, 8'h60);
      wrr(8'h24, 8'h80);
      repeat (3) @(negedge clk);
      rdr(8'h04);
      chk(rv, 8'h40, "update set");
      chk(upd, 1, "update bit");
      wrr(8'h04, 8'h40);
      wrr(8'h24, 8'h00);
      repeat (3) @(negedge clk);
      rdr(8'h04);
      chk(rv, 8'h20, "update clear");
      // Manual point: code 216 gives phase 14 on the rising curve
      shift = 5'h00;
      wrr(8'h33, 8'h42);
      wrr(8'h3A, 8'h6C);
      repeat (4) @(negedge clk);
      wrr(8'h33, 8'h4A);
      rdr(8'h39);
      chk(rv, 8'h4E, "manual low");
      rdr(8'h3A);
      chk(rv, 8'h6C, "manual high");
      close_out();
   end
endmodule
bind mudpc_top mudpc_chk i_mudpc_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_delay_code(o_delay_code),
   .o_locked(o_locked), .o_parameter_update(o_parameter_update), .o_irq(o_irq));
`default_nettype wire
